// [verilog/soc_pkg.sv]
// Constants for the serial output configuration register bank.
// Assumes a 32-bit APB master and a separate link clock domain.
`default_nettype none
package soc_pkg;
	// Printed offsets are register indices; byte address is index * 4
	localparam logic [5:0] IDX_FRAME_CFG = 6'h19;
	localparam logic [5:0] IDX_CURRENT = 6'h1a;
	localparam logic [5:0] IDX_RES_MAP = 6'h1b;
	localparam logic [5:0] IDX_SKEW = 6'h1e;
	localparam logic [5:0] IDX_PAT_LOW = 6'h20;
	localparam logic [5:0] IDX_PAT_MID = 6'h21;
	localparam logic [5:0] IDX_PAT_HIGH = 6'h22;
	localparam logic [5:0] IDX_MODE = 6'h30;
	localparam logic [5:0] IDX_STATUS = 6'h31;
	// Field positions
	localparam int B_SRC = 7;
	localparam int B_DIV = 4;
	localparam int B_STRETCH = 0;
	localparam int B_HALF = 6;
	localparam int B_MAP_EN = 7;
	localparam int B_WIDE = 6;
	localparam int B_RES_LSB = 3;
	localparam int B_DSKEW_LSB = 2;
	localparam int B_CSKEW_LSB = 0;
	// Pattern reset value and bypass patterns per word length
	localparam logic [19:0] PAT_RESET = 20'hffc00;
	localparam logic [19:0] PAT_W20 = 20'hffc00;
	localparam logic [19:0] PAT_W18 = 20'hff800;
	localparam logic [19:0] PAT_W16 = 20'hff000;
	localparam logic [19:0] PAT_W14 = 20'hfe000;
	// Resolution codes and word lengths
	localparam logic [2:0] RES_18 = 3'h0;
	localparam logic [2:0] RES_16 = 3'h1;
	localparam logic [2:0] RES_14 = 3'h2;
	localparam logic [4:0] LEN_20 = 5'h14;
	localparam logic [4:0] LEN_18 = 5'h12;
	localparam logic [4:0] LEN_16 = 5'h10;
	localparam logic [4:0] LEN_14 = 5'h0e;
	// Drive current in microamps, skew step in picoseconds
	localparam logic [11:0] CUR_NORMAL_UA = 12'hdac;
	localparam logic [11:0] CUR_HALF_UA = 12'h6d6;
	localparam int SKEW_STEP_PS = 50;
	typedef enum logic [1:0] {
		DEC_BYPASS = 2'b00,
		DEC_REAL = 2'b01,
		DEC_COMPLEX = 2'b10,
		DEC_COMPLEX_ALT = 2'b11
	} soc_dec_t;
endpackage
`default_nettype wire

// [verilog/soc_top.sv]
// APB register bank for the serial differential output settings,
// with a handshake that carries the settings into the link clock domain.
// Assumes APB on CLK, LINK_CLK free or gated, and the other end keeping its rules.
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Contract
// R1: Bypass or real decimation: 2-wire uses divide 1, others all zero.
// R2: Complex: source 1 for 2/1-wire; half-wire uses stretch only.
// R3: Half current bit drives 1.75 mA instead of 3.5 mA.
// R4: Remap enable changes resolution only in bypass; not needed for 20-bit.
// R5: Wide output enable selects 20-bit words.
// R6: Resolution select 000=18, 001=16, 010=14, others invalid.
// R7: Decimation modes change resolution by select alone, default 18-bit.
// R8: Data skew code 00 none, 01 -50 ps, 10 +50 ps, 11 +100 ps.
// R9: Bit clock skew code decoded the same way as data skew.
// R10: Pattern spans three byte registers, high nibble of third reads zero.
// R11: Pattern resets to 0xFFC00; bypass mode picks it per resolution.
// R12: Frame source 0 uses converter path, 1 uses down-conversion block.
// R13: Stretch lengthens frame to cover channels A and B.
// R14: Software writes zero to reserved bits and configures before capture.
module soc_top #(
	parameter int ADDR_W = 8
) (
	input wire logic CLK,
	input wire logic SRST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [ADDR_W-1:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [3:0] PSTRB,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic LINK_CLK,
	input wire logic DDC_FRAME,
	output logic FRAME_CLOCK,
	output logic FRAME_SOURCE_SEL,
	output logic HALF_DRIVE_CURRENT,
	output logic [11:0] DRIVE_CURRENT_UA,
	output logic [4:0] WORD_BITS,
	output logic [2:0] DATA_LANE_SKEW,
	output logic [2:0] BIT_CLOCK_SKEW
);
	logic src, divide, stretch, half, map_en, wide;
	logic [2:0] res_sel;
	logic [1:0] dskew, cskew, dec_mode;
	logic [19:0] pattern;
	logic [5:0] idx;
	logic wr, setup, hit;
	logic [4:0] res_len;
	logic res_bad;
	logic [19:0] eff_pat;
	logic [33:0] bundle, sent;
	logic req_tog, ack_s1, ack_s2, pending;
	logic lk_rst_s1, lk_rst, req_s1, req_s2, req_s3, ack_tog;
	logic [33:0] lk_cfg;
	logic ddc_s1, ddc_s2;
	logic [4:0] pos, step;
	logic hold;
	logic [31:0] rdata;

	assign idx = PADDR[7:2];
	assign setup = PSEL && !PENABLE && !PREADY;
	assign wr = PSEL && PENABLE && PREADY && PWRITE && PSTRB[0];

	always_comb
	begin
		hit = 1'b1;
		rdata = 32'h0;
		unique case (idx)
			soc_pkg::IDX_FRAME_CFG: rdata[7:0] = {src, 2'h0, divide, 3'h0, stretch};
			soc_pkg::IDX_CURRENT: rdata[soc_pkg::B_HALF] = half;
			soc_pkg::IDX_RES_MAP: rdata[7:0] = {map_en, wide, res_sel, 3'h0};
			soc_pkg::IDX_SKEW: rdata[3:0] = {dskew, cskew};
			soc_pkg::IDX_PAT_LOW: rdata[7:0] = pattern[7:0];
			soc_pkg::IDX_PAT_MID: rdata[7:0] = pattern[15:8];
			// R10 upper nibble reads zero
			soc_pkg::IDX_PAT_HIGH: rdata[3:0] = pattern[19:16];
			soc_pkg::IDX_MODE: rdata[1:0] = dec_mode;
			soc_pkg::IDX_STATUS: rdata[6:0] = {pending, res_bad, res_len};
			default: hit = 1'b0;
		endcase
	end

	// Answer one cycle after setup, so read data comes from a flop
	always_ff @(posedge CLK)
	begin
		if (SRST)
		begin
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA <= 32'h0;
		end
		else
		begin
			PREADY <= setup;
			PSLVERR <= setup && !hit;
			if (setup)
				PRDATA <= PWRITE ? 32'h0 : rdata;
		end
	end

	always_ff @(posedge CLK)
	begin
		if (SRST)
		begin
			src <= 1'b0;
			divide <= 1'b0;
			stretch <= 1'b0;
			half <= 1'b0;
			map_en <= 1'b0;
			wide <= 1'b0;
			res_sel <= soc_pkg::RES_18;
			dskew <= 2'h0;
			cskew <= 2'h0;
			dec_mode <= soc_pkg::DEC_BYPASS;
			// R11 pattern reset value
			pattern <= soc_pkg::PAT_RESET;
		end
		else if (wr)
		begin
			unique case (idx)
				soc_pkg::IDX_FRAME_CFG:
				begin
					src <= PWDATA[soc_pkg::B_SRC];
					divide <= PWDATA[soc_pkg::B_DIV];
					stretch <= PWDATA[soc_pkg::B_STRETCH];
				end
				// R3 half current select
				soc_pkg::IDX_CURRENT: half <= PWDATA[soc_pkg::B_HALF];
				soc_pkg::IDX_RES_MAP:
				begin
					map_en <= PWDATA[soc_pkg::B_MAP_EN];
					wide <= PWDATA[soc_pkg::B_WIDE];
					res_sel <= PWDATA[soc_pkg::B_RES_LSB+:3];
				end
				soc_pkg::IDX_SKEW:
				begin
					dskew <= PWDATA[soc_pkg::B_DSKEW_LSB+:2];
					cskew <= PWDATA[soc_pkg::B_CSKEW_LSB+:2];
				end
				// R10 pattern split over three bytes
				soc_pkg::IDX_PAT_LOW: pattern[7:0] <= PWDATA[7:0];
				soc_pkg::IDX_PAT_MID: pattern[15:8] <= PWDATA[7:0];
				soc_pkg::IDX_PAT_HIGH: pattern[19:16] <= PWDATA[3:0];
				soc_pkg::IDX_MODE: dec_mode <= PWDATA[1:0];
				default:
				begin
				end
			endcase
		end
	end

	// Word length seen by the serializer
	always_comb
	begin
		res_bad = 1'b0;
		res_len = soc_pkg::LEN_18;
		// R5 wide words win
		if (wide)
			res_len = soc_pkg::LEN_20;
		// R4 remap only matters in bypass
		else if (dec_mode == soc_pkg::DEC_BYPASS && !map_en)
			res_len = soc_pkg::LEN_18;
		else
		begin
			// R6 resolution decode
			unique case (res_sel)
				soc_pkg::RES_18: res_len = soc_pkg::LEN_18;
				soc_pkg::RES_16: res_len = soc_pkg::LEN_16;
				soc_pkg::RES_14: res_len = soc_pkg::LEN_14;
				default: res_bad = 1'b1;
			endcase
		end
	end

	// R11 bypass picks the pattern per resolution
	always_comb
	begin
		eff_pat = pattern;
		if (dec_mode == soc_pkg::DEC_BYPASS)
		begin
			unique case (res_len)
				soc_pkg::LEN_20: eff_pat = soc_pkg::PAT_W20;
				soc_pkg::LEN_16: eff_pat = soc_pkg::PAT_W16;
				soc_pkg::LEN_14: eff_pat = soc_pkg::PAT_W14;
				default: eff_pat = soc_pkg::PAT_W18;
			endcase
		end
	end

	assign bundle = {eff_pat, res_len, half, src, divide, stretch, 1'b0, dskew, cskew};
	assign pending = req_tog != ack_s2;

	// Toggle handshake; a change made while busy is sent on the next round
	always_ff @(posedge CLK)
	begin
		if (SRST)
		begin
			req_tog <= 1'b0;
			sent <= 34'h0;
			ack_s1 <= 1'b0;
			ack_s2 <= 1'b0;
		end
		else
		begin
			ack_s1 <= ack_tog;
			ack_s2 <= ack_s1;
			if (!pending && bundle != sent)
			begin
				sent <= bundle;
				req_tog <= !req_tog;
			end
		end
	end

	// Link side: reset, request and frame input synchronisers
	always_ff @(posedge LINK_CLK)
	begin
		lk_rst_s1 <= SRST;
		lk_rst <= lk_rst_s1;
		req_s1 <= req_tog;
		req_s2 <= req_s1;
		ddc_s1 <= DDC_FRAME;
		ddc_s2 <= ddc_s1;
	end

	always_ff @(posedge LINK_CLK)
	begin
		if (lk_rst)
		begin
			req_s3 <= 1'b0;
			ack_tog <= 1'b0;
			lk_cfg <= 34'h0;
		end
		else
		begin
			req_s3 <= req_s2;
			if (req_s2 != req_s3)
			begin
				lk_cfg <= sent;
				ack_tog <= !ack_tog;
			end
		end
	end

	// Divide splits a word over two lanes, so the frame moves two bits per beat
	assign step = lk_cfg[6] ? 5'h2 : 5'h1;

	always_ff @(posedge LINK_CLK)
	begin
		if (lk_rst)
		begin
			pos <= 5'h0;
			hold <= 1'b0;
		end
		// R13 stretch holds each frame bit a second beat
		else if (lk_cfg[5] && !hold)
			hold <= 1'b1;
		else
		begin
			hold <= 1'b0;
			if (pos + step >= lk_cfg[13:9])
				pos <= 5'h0;
			else
				pos <= pos + step;
		end
	end

	always_ff @(posedge LINK_CLK)
	begin
		if (lk_rst)
		begin
			FRAME_CLOCK <= 1'b0;
			FRAME_SOURCE_SEL <= 1'b0;
			HALF_DRIVE_CURRENT <= 1'b0;
			DRIVE_CURRENT_UA <= soc_pkg::CUR_NORMAL_UA;
			WORD_BITS <= soc_pkg::LEN_18;
			DATA_LANE_SKEW <= 3'h0;
			BIT_CLOCK_SKEW <= 3'h0;
		end
		else
		begin
			// R12 frame source mux
			FRAME_CLOCK <= lk_cfg[7] ? ddc_s2 : lk_cfg[14 + 5'd19 - pos];
			FRAME_SOURCE_SEL <= lk_cfg[7];
			// R3 drive current
			HALF_DRIVE_CURRENT <= lk_cfg[8];
			DRIVE_CURRENT_UA <= lk_cfg[8] ? soc_pkg::CUR_HALF_UA : soc_pkg::CUR_NORMAL_UA;
			WORD_BITS <= lk_cfg[13:9];
			// R8 data skew in signed 50 ps steps
			DATA_LANE_SKEW <= skew_steps(lk_cfg[3:2]);
			// R9 bit clock skew in signed 50 ps steps
			BIT_CLOCK_SKEW <= skew_steps(lk_cfg[1:0]);
		end
	end

	// Advance is negative; the analog delay line does the real work
	function automatic logic [2:0] skew_steps(input logic [1:0] code);
		unique case (code)
			2'h0: skew_steps = 3'h0;
			2'h1: skew_steps = 3'h7;
			2'h2: skew_steps = 3'h1;
			2'h3: skew_steps = 3'h2;
		endcase
	endfunction

	sequence s_setup;
		PSEL && !PENABLE && !PREADY;
	endsequence

	sequence s_access;
		PSEL && PENABLE && PREADY;
	endsequence

	chk_apb_answer: assert property (@(posedge CLK) disable iff (SRST)
		s_setup |=> PREADY ##1 !PREADY)
		else $error("APB answer not one cycle after setup");

	chk_unmapped_err: assert property (@(posedge CLK) disable iff (SRST)
		(s_setup and !hit) |=> PSLVERR && PREADY)
		else $error("Unmapped access without error");

	chk_half_write: assert property (@(posedge CLK) disable iff (SRST) // R3
		(s_access and (PWRITE && PSTRB[0] && idx == soc_pkg::IDX_CURRENT))
		|=> half == $past(PWDATA[6]))
		else $error("Half current bit not stored");

	chk_wide_len: assert property (@(posedge CLK) disable iff (SRST) // R5
		wide |-> res_len == soc_pkg::LEN_20)
		else $error("Wide enable not giving 20-bit words");

	chk_bypass_map: assert property (@(posedge CLK) disable iff (SRST) // R4
		dec_mode == soc_pkg::DEC_BYPASS && !wide && !map_en |-> res_len == soc_pkg::LEN_18)
		else $error("Bypass resolution changed without remap");

	chk_res_decode: assert property (@(posedge CLK) disable iff (SRST) // R6
		!wide && dec_mode != soc_pkg::DEC_BYPASS && res_sel == soc_pkg::RES_14
		|-> res_len == soc_pkg::LEN_14 && !res_bad)
		else $error("Resolution 14 decode wrong");

	chk_auto_pat: assert property (@(posedge CLK) disable iff (SRST) // R11
		dec_mode == soc_pkg::DEC_BYPASS && res_len == soc_pkg::LEN_16
		|-> eff_pat == soc_pkg::PAT_W16)
		else $error("Bypass pattern not adjusted");

	chk_pat_reset: assert property (@(posedge CLK) // R11
		$fell(SRST) |-> pattern == soc_pkg::PAT_RESET)
		else $error("Pattern reset value wrong");

	chk_pat_high: assert property (@(posedge CLK) disable iff (SRST) // R10
		(s_setup and (!PWRITE && idx == soc_pkg::IDX_PAT_HIGH)) |=> PRDATA[7:4] == 4'h0)
		else $error("Pattern high nibble not zero");

	chk_data_skew: assert property (@(posedge LINK_CLK) disable iff (lk_rst) // R8
		lk_cfg[3:2] == 2'h3 |=> DATA_LANE_SKEW == 3'h2)
		else $error("Data skew decode wrong");

	chk_clock_skew: assert property (@(posedge LINK_CLK) disable iff (lk_rst) // R9
		lk_cfg[1:0] == 2'h1 |=> BIT_CLOCK_SKEW == 3'h7)
		else $error("Bit clock skew decode wrong");

	chk_ddc_source: assert property (@(posedge LINK_CLK) disable iff (lk_rst) // R12
		lk_cfg[7] |=> FRAME_CLOCK == $past(ddc_s2))
		else $error("Frame source mux wrong");

	chk_stretch_hold: assert property (@(posedge LINK_CLK) disable iff (lk_rst) // R13
		lk_cfg[5] && $stable(lk_cfg) && !hold |=> hold && $stable(pos))
		else $error("Stretch did not hold frame bit");
endmodule
`default_nettype wire

// [tb/soc_rx_model.sv]
// Far-side model: drives the down-conversion frame, counts frames seen.
// Assumes LINK_CLK comes from the bench and runs only while the link is up.
`timescale 1ns/1ps
`default_nettype none
module soc_rx_model (
	input wire logic LINK_CLK,
	input wire logic FRAME_CLOCK,
	output logic DDC_FRAME,
	output logic [15:0] FRAMES
);
	logic last;
	initial DDC_FRAME = 1'b0;
	initial FRAMES = 16'h0;
	initial last = 1'b0;
	always @(posedge LINK_CLK)
	begin
		DDC_FRAME <= ~DDC_FRAME;
		last <= FRAME_CLOCK;
		if (FRAME_CLOCK && !last)
			FRAMES <= FRAMES + 16'h1;
	end
endmodule
`default_nettype wire

// [tb/test_serial_output_config_regs.sv]
// Bench for the output config bank: APB master tasks and checks.
// Assumes one-cycle APB answers and a status pending flag for link updates.
`timescale 1ns/1ps
`default_nettype none
module test_serial_output_config_regs;
	logic clk = 1'b0, lclk = 1'b0, srst = 1'b1;
	logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
	logic [7:0] pa = 8'h0;
	logic [3:0] pstb = 4'hf;
	logic [31:0] pwd = 32'h0, prd, rd;
	logic prdy, perr, err, frame_clock, fsrc, half, ddc;
	logic [11:0] cur;
	logic [4:0] wbits;
	logic [2:0] dsk, csk;
	logic [15:0] frames;
	int errors = 0, comparisons = 0;
	logic [2:0] sk [4] = '{3'h0, 3'h7, 3'h1, 3'h2};
	logic [4:0] len [3] = '{5'h12, 5'h10, 5'h0e};
	logic [7:0] fcfg [4] = '{8'h10, 8'h00, 8'h80, 8'h01};
	always #12.5 clk = ~clk;
	always #24 lclk = ~lclk;
	soc_top uut (.CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(pen),
		.PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PSTRB(pstb), .PRDATA(prd),
		.PREADY(prdy), .PSLVERR(perr), .LINK_CLK(lclk), .DDC_FRAME(ddc),
		.FRAME_CLOCK(frame_clock), .FRAME_SOURCE_SEL(fsrc), .HALF_DRIVE_CURRENT(half),
		.DRIVE_CURRENT_UA(cur), .WORD_BITS(wbits), .DATA_LANE_SKEW(dsk),
		.BIT_CLOCK_SKEW(csk));
	soc_rx_model rx (.LINK_CLK(lclk), .FRAME_CLOCK(frame_clock), .DDC_FRAME(ddc),
		.FRAMES(frames));
	task end_sim;
		$display("checks %0d mismatches %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e)
		begin
			errors++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	// Setup, then access held until PREADY is sampled high
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (prdy !== 1'b1 && n < 50);
		if (n >= 50)
		begin
			errors++;
			end_sim;
		end
		rd = prd;
		err = perr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask
	task rdchk(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk("read", rd, e);
	endtask
	// Waits until the link side has taken the settings
	task sync;
		int n;
		n = 0;
		do
		begin
			xfer(1'b0, 8'hc4, 32'h0);
			n++;
		end
		while (rd[6] !== 1'b0 && n < 100);
		if (n >= 100)
		begin
			errors++;
			end_sim;
		end
		repeat (8) @(posedge clk);
	endtask
	initial
	begin
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		sync;
		rdchk(8'h68, 32'h0);
		rdchk(8'h6c, 32'h0);
		rdchk(8'h78, 32'h0);
		rdchk(8'h80, 32'h0);
		rdchk(8'h84, 32'hfc);
		rdchk(8'h88, 32'h0f);
		chk("width", wbits, soc_pkg::LEN_18);
		chk("frames", frames != 16'h0, 1);
		rdchk(8'hfc, 32'h0);
		chk("slverr", err, 1'b1);
		xfer(1'b1, 8'h88, 32'h05);
		rdchk(8'h88, 32'h05);
		xfer(1'b1, 8'h68, 32'h40);
		sync;
		chk("current", cur, soc_pkg::CUR_HALF_UA);
		chk("half", half, 1'b1);
		xfer(1'b1, 8'h68, 32'h0);
		sync;
		chk("current", cur, soc_pkg::CUR_NORMAL_UA);
		// Write without byte strobe must not land
		pstb <= 4'h0;
		xfer(1'b1, 8'h68, 32'h40);
		pstb <= 4'hf;
		rdchk(8'h68, 32'h0);
		for (int i = 0; i < 4; i++)
		begin
			xfer(1'b1, 8'h78, 32'(i * 5));
			sync;
			chk("dskew", dsk, sk[i]);
			chk("cskew", csk, sk[i]);
		end
		for (int i = 0; i < 3; i++)
		begin
			xfer(1'b1, 8'h6c, 32'h80 | 32'(i * 8));
			sync;
			chk("width", wbits, len[i]);
		end
		xfer(1'b1, 8'h6c, 32'h98);
		sync;
		rdchk(8'hc4, 32'h32);
		xfer(1'b1, 8'h6c, 32'h40);
		sync;
		chk("width", wbits, soc_pkg::LEN_20);
		xfer(1'b1, 8'hc0, 32'h1);
		sync;
		xfer(1'b1, 8'h6c, 32'h08);
		sync;
		chk("width", wbits, soc_pkg::LEN_16);
		xfer(1'b1, 8'h6c, 32'h10);
		sync;
		chk("width", wbits, soc_pkg::LEN_14);
		for (int i = 0; i < 4; i++)
		begin
			xfer(1'b1, 8'hc0, (i < 2) ? 32'h0 : 32'h2);
			// One link update in flight at a time
			sync;
			xfer(1'b1, 8'h64, 32'(fcfg[i]));
			sync;
			rdchk(8'h64, 32'(fcfg[i]));
			chk("fsrc", fsrc, fcfg[i][7]);
		end
		end_sim;
	end
endmodule
`default_nettype wire
